// >>> rtl/sfrd_pkg.sv
// Constants and types for the serial flash read controller.
// Assumes a 25 MHz system clock; the flash serial clock is divided from it.
package sfrd_pkg;
   // Read opcodes
   localparam logic [7:0] NORMAL_READ_CMD            = 8'h03;
   localparam logic [7:0] NORMAL_READ_WIDE_ADDR_CMD  = 8'h13;
   localparam logic [7:0] FAST_READ_CMD              = 8'h0B;
   localparam logic [7:0] FAST_READ_WIDE_ADDR_CMD    = 8'h0C;
   localparam logic [7:0] DUAL_IO_READ_CMD           = 8'hBB;
   localparam logic [7:0] DUAL_IO_READ_WIDE_ADDR_CMD = 8'hBC;
   localparam logic [7:0] QUAD_IO_READ_CMD           = 8'hEB;
   localparam logic [7:0] UNIQUE_ID_READ_CMD         = 8'h4B;
   localparam logic [7:0] INFO_ROW_READ_CMD          = 8'h68;
   // Timing
   localparam int CLK_PERIOD_NS       = 40;
   localparam int SCK_PERIOD_NS       = 320;
   localparam int SCK_HALF_DEF        = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int CLK_MHZ             = 25;
   localparam int NORMAL_READ_MAX_MHZ = 50;
   localparam int FAST_READ_MAX_MHZ   = 133;
   localparam int MIN_HALF_NORMAL     = (CLK_MHZ + 2 * NORMAL_READ_MAX_MHZ - 1)
                                        / (2 * NORMAL_READ_MAX_MHZ);
   // Frame lengths, in bits or clocks
   localparam logic [5:0] OPCODE_BITS       = 6'h08;
   localparam logic [5:0] ADDR3_BITS        = 6'h18;
   localparam logic [5:0] ADDR4_BITS        = 6'h20;
   localparam logic [5:0] BYTE_BITS         = 6'h08;
   localparam logic [5:0] MODE_CLKS         = 6'h04;
   localparam logic [5:0] MODE_NIBBLE_CLKS  = 6'h02;
   localparam logic [5:0] CNT_ONE           = 6'h01;
   localparam logic [5:0] DUMMY_FAST_DEF    = 6'h08;
   localparam logic [5:0] DUMMY_FOUR_W_DEF  = 6'h06;
   localparam logic [5:0] DUMMY_DUAL_DEF    = 6'h04;
   localparam logic [3:0] CONT_NIBBLE       = 4'hA;
   // Lane widths as log2
   localparam logic [1:0] LG_SINGLE = 2'h0;
   localparam logic [1:0] LG_DUAL   = 2'h1;
   localparam logic [1:0] LG_QUAD   = 2'h2;
   localparam logic [3:0] MASK_SINGLE = 4'h1;
   localparam logic [3:0] MASK_DUAL   = 4'h3;
   localparam logic [3:0] MASK_QUAD   = 4'hF;
   localparam logic [3:0] MASK_SIDE   = 4'hC;
   localparam int DATA_W         = 8;
   localparam int FIFO_DEPTH_DEF = 16;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [31:0] addr;
      logic [15:0] len;
      logic [4:0]  dummy;
      logic [7:0]  mode;
   } sfrd_req_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_LOAD, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_END
   } sfrd_state_t;
endpackage : sfrd_pkg

// >>> rtl/sfrd_fifo.sv
// Read data FIFO between the flash engine and the user.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sfrd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Drain side
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    rd_ff;
   logic [AW:0]      count_ff;
   wire              wr = in_valid & in_ready;
   wire              rd = out_valid & out_ready;

   assign in_ready  = count_ff != (AW+1)'(DEPTH);
   assign out_valid = count_ff != '0;
   assign out_data  = mem_ff[rd_ff];

   // Storage is not reset; count gates every read
   always_ff @(posedge clk) begin
      if (wr) mem_ff[wr_ff] <= in_data;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ff    <= '0;
         rd_ff    <= '0;
         count_ff <= '0;
      end else begin
         if (wr) wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
         if (rd) rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
         count_ff <= count_ff + (AW+1)'(wr) - (AW+1)'(rd);
      end
   end
endmodule : sfrd_fifo
`default_nettype wire

// >>> rtl/sfrd_host.sv
// Host controller issuing read commands to a serial NOR flash.
// Drives the flash clock (mode 0), select, hold and IO lines; IO inputs
// come from the flash's domain and are synchronised here.
// How it works
// - Opcode 03h sends 3 or 4 address bytes by ext flag; 13h always 4.
// - Normal read serial clock never exceeds 50 MHz.
// - Raising select ends any read; flash releases output and waits.
// - Opcode 0Bh uses ext flag for address length; 0Ch always 4 bytes.
// - Single-line fast read: rising-edge input, default 8 dummies, falling-edge data.
// - Four-wire mode: opcode 2 clocks, address 6 or 8, default 6 dummies.
// - Hold falls and rises only while serial clock is low; sequence kept.
// - Dual-IO BBh/BCh address two bits per clock, MSB on line 1, 4 dummies.
// - Mode byte takes four clocks inside the dummies; data may follow at once.
// - Host floats mode low nibble when dummies equal mode clocks.
`timescale 1ns/1ps
`default_nettype none
module sfrd_host
   import sfrd_pkg::*;
#(
   parameter int SCK_HALF   = sfrd_pkg::SCK_HALF_DEF,
   parameter int FIFO_DEPTH = sfrd_pkg::FIFO_DEPTH_DEF
) (
   // Clock and reset
   input  wire logic              CLOCK,
   input  wire logic              SYS_RST,
   // Command port
   input  wire logic              START,
   input  wire sfrd_pkg::sfrd_req_t REQ,
   input  wire logic              EXT_ADDR,
   input  wire logic              FOUR_WIRE,
   input  wire logic              QUAD_EN,
   input  wire logic              WRITE_IN_PROGRESS_FLAG,
   input  wire logic              HOLD_REQ,
   input  wire logic              ABORT,
   output logic                   BUSY,
   output logic                   REFUSED,
   output logic                   CONT_MODE,
   // Read data
   output logic [sfrd_pkg::DATA_W-1:0] RD_DATA,
   output logic                   RD_VALID,
   input  wire logic              RD_READY,
   // Flash pins
   output logic                   SCK,
   output logic                   CS_N,
   input  wire logic [3:0]        IO_IN,
   output logic [3:0]             IO_OUT,
   output logic [3:0]             IO_OE_N
);
   import sfrd_pkg::*;

   function automatic logic f_dual(input logic [7:0] op);
      return op == DUAL_IO_READ_CMD || op == DUAL_IO_READ_WIDE_ADDR_CMD;
   endfunction : f_dual

   function automatic logic [3:0] f_mask(input logic [1:0] lg);
      return (lg == LG_QUAD) ? MASK_QUAD : (lg == LG_DUAL) ? MASK_DUAL : MASK_SINGLE;
   endfunction : f_mask

   sfrd_state_t state_ff, nxt_state, ld_state, tgt_state;
   sfrd_req_t   req_ff;
   logic [5:0]  cnt_ff, nxt_cnt, ld_cnt;
   logic [31:0] tx_ff, nxt_tx, ld_tx;
   logic [1:0]  lg_ff, nxt_lg, ld_lg;
   logic [7:0]  rx_ff, nxt_rx, push_data_ff;
   logic [15:0] bytes_ff;
   logic [$clog2(SCK_HALF+1)-1:0] div_ff;
   logic        sck_ff, cs_n_ff, hold_n_ff, cont_ff, ext_ff, four_ff;
   logic        push_ff, refused_ff;
   logic [3:0]  s1_ff, s2_ff, s3_ff, io_val_ff, io_out_ff, io_oe_n_ff;
   logic        fifo_in_ready;

   // Decode of the latched command
   wire op_normal = req_ff.opcode == NORMAL_READ_CMD
                  || req_ff.opcode == NORMAL_READ_WIDE_ADDR_CMD;
   wire op_wide   = req_ff.opcode == NORMAL_READ_WIDE_ADDR_CMD
                  || req_ff.opcode == FAST_READ_WIDE_ADDR_CMD
                  || req_ff.opcode == DUAL_IO_READ_WIDE_ADDR_CMD;
   wire op_shared = req_ff.opcode == NORMAL_READ_CMD || req_ff.opcode == FAST_READ_CMD
                  || req_ff.opcode == DUAL_IO_READ_CMD
                  || req_ff.opcode == QUAD_IO_READ_CMD;
   wire addr4     = op_wide | (ext_ff & op_shared);
   wire dual      = f_dual(req_ff.opcode);
   wire mode_en   = dual & ~four_ff;
   wire skip_cmd  = cont_ff & dual;
   wire [1:0] lg_cmd = four_ff ? LG_QUAD : LG_SINGLE;
   wire [1:0] lg_io  = four_ff ? LG_QUAD : (dual ? LG_DUAL : LG_SINGLE);
   wire [5:0] dum_def = four_ff ? DUMMY_FOUR_W_DEF
                      : (dual ? DUMMY_DUAL_DEF : DUMMY_FAST_DEF);
   wire [5:0] dummy   = op_normal ? '0
                      : (req_ff.dummy != '0 ? 6'(req_ff.dummy) : dum_def);
   wire [5:0] dum_rest = !mode_en ? dummy : (dummy > MODE_CLKS ? dummy - MODE_CLKS : '0);
   wire       rest_zero = dum_rest == '0;
   wire [31:0] addr_word = addr4 ? req_ff.addr : {req_ff.addr[23:0], 8'h00};
   wire [5:0]  addr_clks = (addr4 ? ADDR4_BITS : ADDR3_BITS) >> lg_io;

   // Start decisions use the live request
   wire idle   = state_ff == ST_IDLE;
   wire refuse = START & idle & (WRITE_IN_PROGRESS_FLAG | REQ.len == '0
               | (cont_ff & ~f_dual(REQ.opcode))
               | (REQ.opcode == QUAD_IO_READ_CMD & ~FOUR_WIRE));
   wire go     = START & idle & ~refuse;

   // Serial clock generation
   wire active = state_ff inside {ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA};
   // Abort freezes the clock too, so select never rises with the clock high
   wire abort_now = ABORT & active & ~sck_ff;
   wire hold_ok = ~QUAD_EN & ~FOUR_WIRE;
   wire pause  = ~sck_ff & (~hold_n_ff | (state_ff == ST_DATA & ~fifo_in_ready));
   wire run    = active & ~pause & ~abort_now;
   wire div_end = (run | state_ff == ST_END) && div_ff == $bits(div_ff)'(SCK_HALF - 1);
   wire rise   = run & div_end & ~sck_ff;
   wire fall   = run & div_end & sck_ff;
   wire last   = cnt_ff == CNT_ONE;

   always_comb begin
      case (state_ff)
         ST_CMD:   tgt_state = ST_ADDR;
         ST_ADDR:  tgt_state = mode_en ? ST_MODE : (rest_zero ? ST_DATA : ST_DUMMY);
         ST_MODE:  tgt_state = rest_zero ? ST_DATA : ST_DUMMY;
         ST_DUMMY: tgt_state = ST_DATA;
         ST_DATA:  tgt_state = (bytes_ff == '0) ? ST_END : ST_DATA;
         default:  tgt_state = skip_cmd ? ST_ADDR : ST_CMD;
      endcase
      ld_state = tgt_state;
      ld_tx    = tx_ff;
      ld_lg    = lg_io;
      case (tgt_state)
         ST_CMD:   begin
            ld_cnt = OPCODE_BITS >> lg_cmd;
            ld_tx  = {req_ff.opcode, 24'h000000};
            ld_lg  = lg_cmd;
         end
         ST_ADDR:  begin
            ld_cnt = addr_clks;
            ld_tx  = addr_word;
         end
         ST_MODE:  begin
            ld_cnt = MODE_CLKS;
            ld_tx  = {req_ff.mode, 24'h000000};
            ld_lg  = LG_DUAL;
         end
         ST_DUMMY: ld_cnt = dum_rest;
         default:  ld_cnt = BYTE_BITS >> lg_io;
      endcase
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_tx    = tx_ff;
      nxt_lg    = lg_ff;
      if (idle) begin
         if (go) nxt_state = ST_LOAD;
      end else if (state_ff == ST_END) begin
         if (div_end) nxt_state = ST_IDLE;
      end else if (abort_now) begin
         nxt_state = ST_END;
      end else if (state_ff == ST_LOAD || (fall && last)) begin
         nxt_state = ld_state;
         nxt_cnt   = ld_cnt;
         nxt_tx    = ld_tx;
         nxt_lg    = ld_lg;
      end else if (fall) begin
         nxt_cnt = cnt_ff - CNT_ONE;
         nxt_tx  = tx_ff << (6'h01 << lg_ff);
      end
   end

   // Counts once stages two and three agree; the held copy alone lands a bit late
   wire [3:0] io_now = (s2_ff & s3_ff) | (io_val_ff & (s2_ff | s3_ff));
   // Input bits by lane width; single data arrives on line 1
   always_comb begin
      case (lg_ff)
         LG_QUAD: nxt_rx = {rx_ff[3:0], io_now};
         LG_DUAL: nxt_rx = {rx_ff[5:0], io_now[1:0]};
         default: nxt_rx = {rx_ff[6:0], io_now[1]};
      endcase
   end

   // Output lanes; line 1 carries the earlier bit of a pair
   wire [3:0] tx_bits = (lg_ff == LG_QUAD) ? tx_ff[31:28]
                      : (lg_ff == LG_DUAL) ? {2'b00, tx_ff[31:30]} : {3'b000, tx_ff[31]};
   wire float_lo = state_ff == ST_MODE && rest_zero && cnt_ff <= MODE_NIBBLE_CLKS;
   wire drive    = state_ff inside {ST_CMD, ST_ADDR, ST_MODE} && !float_lo;
   wire [3:0] lane_en = (drive ? f_mask(lg_ff) : 4'h0) | (hold_ok ? MASK_SIDE : 4'h0);
   wire [3:0] io_dat  = hold_ok ? {hold_n_ff, 1'b1, tx_bits[1:0]} : tx_bits;

   // Hold only changes while the serial clock is low and not about to rise
   wire hold_set = HOLD_REQ & hold_ok & active & ~sck_ff & ~div_end;
   wire hold_clr = ~HOLD_REQ | ~hold_ok | ~active;

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= '0;
         tx_ff    <= '0;
         lg_ff    <= LG_SINGLE;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         tx_ff    <= nxt_tx;
         lg_ff    <= nxt_lg;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         req_ff  <= '0;
         ext_ff  <= 1'b0;
         four_ff <= 1'b0;
      end else if (go) begin
         req_ff  <= REQ;
         ext_ff  <= EXT_ADDR;
         four_ff <= FOUR_WIRE;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         div_ff  <= '0;
         sck_ff  <= 1'b0;
         cs_n_ff <= 1'b1;
      end else begin
         div_ff  <= (div_end || !(run || state_ff == ST_END)) ? '0 : div_ff + 1'b1;
         sck_ff  <= (run & div_end) ? ~sck_ff : sck_ff;
         cs_n_ff <= nxt_state inside {ST_IDLE, ST_LOAD, ST_END};
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         hold_n_ff <= 1'b1;
      end else if (hold_clr && !sck_ff) begin
         hold_n_ff <= 1'b1;
      end else if (hold_set) begin
         hold_n_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         rx_ff        <= '0;
         push_ff      <= 1'b0;
         push_data_ff <= '0;
         bytes_ff     <= '0;
      end else begin
         if (rise && state_ff == ST_DATA) rx_ff <= nxt_rx;
         push_ff <= rise && state_ff == ST_DATA && last;
         if (rise && state_ff == ST_DATA && last) push_data_ff <= nxt_rx;
         if (state_ff == ST_LOAD) bytes_ff <= req_ff.len;
         else if (rise && state_ff == ST_DATA && last) bytes_ff <= bytes_ff - 1'b1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         cont_ff    <= 1'b0;
         refused_ff <= 1'b0;
         io_out_ff  <= 4'hF;
         io_oe_n_ff <= 4'hF;
      end else begin
         if (fall && last && state_ff == ST_MODE)
            cont_ff <= req_ff.mode[7:4] == CONT_NIBBLE;
         refused_ff <= refuse;
         io_out_ff  <= io_dat;
         io_oe_n_ff <= ~lane_en;
      end
   end

   // Three-stage sync; a change counts once stages two and three agree
   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge CLOCK) begin
         if (SYS_RST) begin
            s1_ff[i]     <= 1'b0;
            s2_ff[i]     <= 1'b0;
            s3_ff[i]     <= 1'b0;
            io_val_ff[i] <= 1'b0;
         end else begin
            s1_ff[i] <= IO_IN[i];
            s2_ff[i] <= s1_ff[i];
            s3_ff[i] <= s2_ff[i];
            if (s2_ff[i] == s3_ff[i]) io_val_ff[i] <= s3_ff[i];
         end
      end
   end

   sfrd_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (CLOCK),
      .rst       (SYS_RST),
      .in_valid  (push_ff),
      .in_data   (push_data_ff),
      .in_ready  (fifo_in_ready),
      .out_valid (RD_VALID),
      .out_data  (RD_DATA),
      .out_ready (RD_READY)
   );

   assign BUSY      = ~idle;
   assign REFUSED   = refused_ff;
   assign CONT_MODE = cont_ff;
   assign SCK       = sck_ff;
   assign CS_N      = cs_n_ff;
   assign IO_OUT    = io_out_ff;
   assign IO_OE_N   = io_oe_n_ff;

   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   logic [7:0]  lo_cnt_ff;
   sfrd_state_t prev_state_ff;
   // Saturates so a long idle low phase cannot wrap to a small count
   always_ff @(posedge CLOCK) begin
      lo_cnt_ff     <= (SYS_RST || sck_ff) ? '0 : lo_cnt_ff + 8'(lo_cnt_ff != 8'hFF);
      prev_state_ff <= state_ff;
   end
   wire enter_addr = state_ff == ST_ADDR && prev_state_ff != ST_ADDR;

   sequence s_cmd_two;
      state_ff == ST_CMD && $past(state_ff) == ST_LOAD && cnt_ff == 6'h02;
   endsequence
   sequence s_addr_quad;
      ##[1:300] (state_ff == ST_ADDR && (cnt_ff == 6'h06 || cnt_ff == 6'h08));
   endsequence

   property p_addr_03;
      enter_addr && req_ff.opcode == NORMAL_READ_CMD && !four_ff
         |-> cnt_ff == (ext_ff ? 6'h20 : 6'h18);
   endproperty
   a_addr_03: assert property (p_addr_03) else $error("bad 03h address length");
   property p_normal_rate;
      $rose(sck_ff) && op_normal |-> $past(lo_cnt_ff) + 8'h01 >= 8'(MIN_HALF_NORMAL);
   endproperty
   a_normal_rate: assert property (p_normal_rate) else $error("normal read clock fast");
   property p_abort;
      abort_now |=> state_ff == ST_END ##1 CS_N;
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not deselect");
   property p_addr_0c;
      enter_addr && req_ff.opcode == FAST_READ_WIDE_ADDR_CMD && !four_ff |-> cnt_ff == 6'h20;
   endproperty
   a_addr_0c: assert property (p_addr_0c) else $error("0Ch not 4-byte");
   property p_fast_dummy;
      state_ff == ST_DUMMY && $past(state_ff) == ST_ADDR && !four_ff && !dual
         && req_ff.dummy == '0 |-> cnt_ff == 6'h08;
   endproperty
   a_fast_dummy: assert property (p_fast_dummy) else $error("fast dummy not 8");
   property p_four_wire;
      s_cmd_two |-> s_addr_quad;
   endproperty
   a_four_wire: assert property (p_four_wire) else $error("four-wire framing");
   property p_hold_low;
      !hold_n_ff |-> !sck_ff ##1 (!sck_ff || hold_n_ff);
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("clock moved in hold");
   property p_dual_addr;
      enter_addr && req_ff.opcode == DUAL_IO_READ_WIDE_ADDR_CMD && !four_ff
         |-> cnt_ff == 6'h10 && lg_ff == LG_DUAL;
   endproperty
   a_dual_addr: assert property (p_dual_addr) else $error("dual address framing");
   property p_mode_data;
      fall && last && state_ff == ST_MODE && dummy == MODE_CLKS |=> state_ff == ST_DATA;
   endproperty
   a_mode_data: assert property (p_mode_data) else $error("data not after mode");
   property p_float_lo;
      float_lo |=> IO_OE_N[1:0] == 2'b11;
   endproperty
   a_float_lo: assert property (p_float_lo) else $error("mode low nibble driven");
endmodule : sfrd_host
`default_nettype wire

// >>> testbench/sfrd_flash_model.sv
// Behavioural serial flash that answers single-line and dual-I/O reads.
// Assumes pull-ups on all four lines; four-wire command mode is not modelled.
`timescale 1ns/1ps
`default_nettype none
module sfrd_flash_model (
   // Host pins
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe_n,
   // Device state
   input  wire logic       ext,
   input  wire logic       qe,
   // Resolved lines
   output logic [3:0]      io
);
   logic [3:0] drv;
   logic [3:0] en;
   logic [7:0] op;
   logic       cont;
   logic       hold_n;
   assign hold_n = qe | io_out[3] | io_oe_n[3];
   // Released lines float to the pull-up
   assign io = (~io_oe_n & io_out) | (io_oe_n & ~(en & {4{hold_n}}))
               | (io_oe_n & en & {4{hold_n}} & drv);
   initial begin
      cont = 1'b0;
      en = 4'h0;
      drv = 4'h0;
      op = 8'h00;
   end
   // Edges seen while paused do not count
   task automatic rise;
      do @(posedge sck); while (!hold_n);
   endtask : rise
   always @(negedge cs_n) begin : frame
      logic [31:0] a;
      logic [7:0]  m;
      logic [7:0]  d;
      logic        dual;
      int          w;
      int          nd;
      a = 32'h0;
      m = 8'h00;
      if (!cont) for (int i = 0; i < 8; i++) begin
         rise();
         op = {op[6:0], io[0]};
      end
      dual = (op == 8'hBB) || (op == 8'hBC);
      w = (ext || op == 8'h13 || op == 8'h0C || op == 8'hBC) ? 32 : 24;
      for (int i = 0; i < w; i += dual ? 2 : 1) begin
         rise();
         a = dual ? {a[29:0], io[1], io[0]} : {a[30:0], io[0]};
      end
      nd = (op == 8'h03 || op == 8'h13) ? 0 : dual ? 4 : 8;
      for (int i = 0; i < nd; i++) begin
         rise();
         m = {m[5:0], io[1], io[0]};
      end
      if (dual) cont = (m[7:4] == 4'hA);
      a = (w == 32) ? {5'h00, a[26:0]} : {8'h00, a[23:0]};
      forever begin
         d = a[7:0] ^ a[23:16] ^ 8'h3C;
         for (int b = 0; b < 8; b += dual ? 2 : 1) begin
            @(negedge sck);
            en = dual ? 4'h3 : 4'h2;
            drv = {2'h0, d[7], dual ? d[6] : 1'b0};
            d = dual ? d << 2 : d << 1;
         end
         a = (a + 32'h1) & 32'h07FFFFFF;
      end
   end
   always @(posedge cs_n) begin
      disable frame;
      en = 4'h0;
   end
endmodule : sfrd_flash_model
`default_nettype wire

// >>> testbench/sfrd_host_tb.sv
// Self-checking bench for the serial flash read controller.
// Assumes the flash model above and the package under rtl/.
`timescale 1ns/1ps
`default_nettype none
module sfrd_host_tb;
   import sfrd_pkg::*;
   logic       clock, sys_rst, start, ext_addr, four_wire, quad_en, write_in_progress_flag, hold_req, abort;
   logic       busy, refused, cont_mode, rd_valid, rd_ready, sck, cs_n;
   logic [7:0] rd_data;
   logic [3:0] io, io_out, io_oe_n;
   sfrd_req_t  req;
   int         err_count = 0;
   int         check_count = 0;
   int         got;
   sfrd_host #(.SCK_HALF(4), .FIFO_DEPTH(16)) dut_u (
      .CLOCK(clock), .SYS_RST(sys_rst), .START(start), .REQ(req), .EXT_ADDR(ext_addr),
      .FOUR_WIRE(four_wire), .QUAD_EN(quad_en), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag), .HOLD_REQ(hold_req),
      .ABORT(abort), .BUSY(busy), .REFUSED(refused), .CONT_MODE(cont_mode),
      .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_READY(rd_ready), .SCK(sck),
      .CS_N(cs_n), .IO_IN(io), .IO_OUT(io_out), .IO_OE_N(io_oe_n));
   sfrd_flash_model flash_u (.sck(sck), .cs_n(cs_n), .io_out(io_out), .io_oe_n(io_oe_n),
      .ext(ext_addr), .qe(quad_en), .io(io));
   initial clock = 1'b0;
   always #20 clock = ~clock;
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   // One read; stall holds the drain side off, abt aborts after that many bytes
   task automatic rd(input logic [7:0] op, input logic [31:0] a, input logic [15:0] n,
      input logic x, input logic [7:0] m, input int stall, input int abt);
      int          t;
      logic        seen;
      logic [26:0] ea;
      t = 0;
      seen = 1'b0;
      got = 0;
      ea = (x || op == 8'h13 || op == 8'h0C || op == 8'hBC) ? a[26:0] : {3'h0, a[23:0]};
      req = '{op, a, n, 5'h00, m};
      ext_addr = x;
      start = 1'b1;
      repeat (3) begin
         @(negedge clock);
         start = 1'b0;
         seen = seen | (refused === 1'b1);
      end
      chk("refused", {7'h0, write_in_progress_flag}, {7'h0, seen});
      while ((busy !== 1'b0 || rd_valid === 1'b1) && t < 40000) begin
         rd_ready = (t >= stall);
         if (rd_valid === 1'b1 && rd_ready) begin
            if (!four_wire) chk("rd_data", ea[7:0] ^ ea[23:16] ^ 8'h3C, rd_data);
            ea = ea + 27'h1;
            got++;
         end
         abort = (abt != 0 && got >= abt);
         @(negedge clock);
         t++;
      end
      abort = 1'b0;
      rd_ready = 1'b0;
      if (abt == 0) chk("bytes", write_in_progress_flag ? 8'h00 : n[7:0], 8'(got));
      chk("busy", 8'h00, {7'h0, busy});
      chk("cs_n", 8'h01, {7'h0, cs_n});
   endtask : rd
   // Pause in mid-address; with quad enable set the pause pin must stay released
   task automatic hold_run(input logic q);
      quad_en = q;
      fork
         rd(8'h0B, 32'h00000300, 4, 1'b0, 8'h00, 0, 0);
         begin
            repeat (150) @(negedge clock);
            hold_req = 1'b1;
            repeat (200) @(negedge clock);
            chk("hold_pin", {7'h0, q}, {7'h0, io[3]});
            hold_req = 1'b0;
         end
      join
      quad_en = 1'b0;
   endtask : hold_run
   initial begin
      repeat (60000) @(posedge clock);
      err_count++;
      close_out();
   end
   initial begin
      sys_rst = 1'b1;
      {start, ext_addr, four_wire, quad_en, write_in_progress_flag, hold_req, abort, rd_ready} = 8'h00;
      req = '0;
      repeat (16) @(negedge clock);
      sys_rst = 1'b0;
      rd(8'h03, 32'h12345678, 3, 1'b0, 8'h00, 0, 0);
      rd(8'h03, 32'hFFFFFFFF, 2, 1'b1, 8'h00, 0, 0);
      rd(8'h13, 32'h00ABCDEF, 2, 1'b0, 8'h00, 0, 0);
      rd(8'h0B, 32'h00FFFFFE, 3, 1'b0, 8'h00, 0, 0);
      rd(8'h0C, 32'h05000010, 20, 1'b0, 8'h00, 3000, 0);
      rd(8'hBB, 32'h00001234, 2, 1'b0, 8'hA5, 0, 0);
      chk("cont_mode", 8'h01, {7'h0, cont_mode});
      rd(8'hBB, 32'h00005678, 2, 1'b0, 8'h00, 0, 0);
      chk("cont_mode", 8'h00, {7'h0, cont_mode});
      rd(8'h03, 32'h00000100, 1, 1'b0, 8'h00, 0, 0);
      rd(8'hBC, 32'h01234560, 2, 1'b0, 8'h00, 0, 0);
      four_wire = 1'b1;
      rd(8'hEB, 32'h00000400, 2, 1'b0, 8'h00, 0, 0);
      four_wire = 1'b0;
      rd(8'h0B, 32'h00000200, 100, 1'b0, 8'h00, 0, 3);
      chk("aborted", 8'h01, {7'h0, got < 100});
      write_in_progress_flag = 1'b1;
      rd(8'h03, 32'h00000000, 1, 1'b0, 8'h00, 0, 0);
      chk("bytes", 8'h00, got[7:0]);
      write_in_progress_flag = 1'b0;
      hold_run(1'b0);
      hold_run(1'b1);
      close_out();
   end
endmodule : sfrd_host_tb
`default_nettype wire
